// ==== token_limiter_pkg.sv ====
package token_limiter_pkg;

  // Group table layout
  localparam int unsigned GROUP_STRIDE = 64;
  localparam int unsigned TOKEN_CFG_OFFSET = 40;
  localparam int unsigned ADDR_W = 16;

  // Field positions inside the token configuration word
  localparam int unsigned ALLOWED_LSB = 20;
  localparam int unsigned ALLOWED_MSB = 27;
  localparam int unsigned RESERVED_LSB = 8;
  localparam int unsigned RESERVED_MSB = 15;
  localparam int unsigned TOKEN_W = 8;

  typedef logic [TOKEN_W-1:0] token_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic bw_tokens_supported;
    logic config_supported;
    token_t total_tokens;
  } caps_s;

endpackage : token_limiter_pkg

// ==== token_cfg_mem.sv ====
module token_cfg_mem
  import token_limiter_pkg::*;
#(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned IDX_W = 2
) (
  input wire logic mclk_i,
  input wire logic we_i,
  input wire logic [IDX_W-1:0] widx_i,
  input wire logic [31:0] wdata_i,
  input wire logic [IDX_W-1:0] ridx_i,
  output logic [31:0] rdata_o
);

  logic [31:0] mem [DEPTH];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[widx_i] <= wdata_i;
    end
    rdata_o <= mem[ridx_i];
  end

endmodule : token_cfg_mem

// ==== group_bandwidth_token_limiter.sv ====
module group_bandwidth_token_limiter
  import token_limiter_pkg::*;
#(
  parameter int unsigned NUM_GROUPS = 4,
  parameter int unsigned NUM_ENGINES = 4,
  parameter int unsigned GRP_W = 2,
  parameter logic [ADDR_W-1:0] TABLE_BASE = 16'h0400
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire reg_req_s req_i,
  input wire caps_s caps_i,
  input wire logic device_enabled_i,
  input wire logic [NUM_ENGINES*GRP_W-1:0] engine_group_i,
  input wire logic [NUM_ENGINES-1:0] take_req_i,
  input wire logic [NUM_ENGINES-1:0] give_back_i,
  output logic [NUM_ENGINES-1:0] take_grant_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic [NUM_GROUPS*TOKEN_W-1:0] in_use_o
);

  // Elaboration-time guard on the group and engine counts
  if (GRP_W == 0 || NUM_GROUPS == 0 || NUM_ENGINES == 0
      || NUM_GROUPS > (1 << GRP_W)) begin : g_param_check
    $error("group_bandwidth_token_limiter: bad parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [ADDR_W-1:0] word_addr(input int unsigned g);
    word_addr = ADDR_W'(TABLE_BASE + g * GROUP_STRIDE + TOKEN_CFG_OFFSET);
  endfunction : word_addr

  logic hit;
  logic [GRP_W-1:0] hit_idx;

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (req_i.addr == word_addr(g)) begin
        hit = 1'b1;
        hit_idx = GRP_W'(g);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields, kept in flops for the limiter

  token_t allowed [NUM_GROUPS];
  token_t reserved [NUM_GROUPS];
  token_t next_allowed [NUM_GROUPS];
  token_t next_reserved [NUM_GROUPS];
  logic cfg_we;

  // Writes are silently dropped while locked
  assign cfg_we = req_i.wr && hit && !device_enabled_i && caps_i.config_supported
                  && caps_i.bw_tokens_supported;

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      next_allowed[g] = allowed[g];
      next_reserved[g] = reserved[g];
      if (rst_i) begin
        next_allowed[g] = caps_i.total_tokens;
        next_reserved[g] = '0;
      end else if (cfg_we && hit_idx == GRP_W'(g)) begin
        next_allowed[g] = req_i.wdata[ALLOWED_MSB:ALLOWED_LSB];
        next_reserved[g] = req_i.wdata[RESERVED_MSB:RESERVED_LSB];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    allowed <= next_allowed;
    reserved <= next_reserved;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow memory for read-back

  function automatic logic [31:0] pack_word(input token_t a, input token_t r);
    pack_word = '0;
    pack_word[ALLOWED_MSB:ALLOWED_LSB] = a;
    pack_word[RESERVED_MSB:RESERVED_LSB] = r;
  endfunction : pack_word

  logic mem_we;
  logic [GRP_W-1:0] mem_widx;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [GRP_W-1:0] init_idx;
  logic [GRP_W-1:0] next_init_idx;
  logic init_busy;
  logic next_init_busy;

  // Reset value sweep through the memory after reset
  always_comb begin
    next_init_idx = init_idx;
    next_init_busy = init_busy;
    if (rst_i) begin
      next_init_idx = '0;
      next_init_busy = 1'b1;
    end else if (init_busy) begin
      next_init_idx = GRP_W'(init_idx + 1'b1);
      if (32'(init_idx) == NUM_GROUPS - 1) begin
        next_init_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    init_idx <= next_init_idx;
    init_busy <= next_init_busy;
  end

  always_comb begin
    mem_we = 1'b0;
    mem_widx = hit_idx;
    mem_wdata = '0;
    if (init_busy) begin
      mem_we = 1'b1;
      mem_widx = init_idx;
      mem_wdata = pack_word(caps_i.total_tokens, '0);
    end else if (cfg_we) begin
      mem_we = 1'b1;
      mem_wdata = pack_word(req_i.wdata[ALLOWED_MSB:ALLOWED_LSB],
                            req_i.wdata[RESERVED_MSB:RESERVED_LSB]);
    end
  end

  token_cfg_mem #(
    .DEPTH(NUM_GROUPS),
    .IDX_W(GRP_W)
  ) u_mem (
    .mclk_i(mclk_i),
    .we_i(mem_we),
    .widx_i(mem_widx),
    .wdata_i(mem_wdata),
    .ridx_i(hit_idx),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read answer, two cycles after the request

  logic rd_d;
  logic rd_hit_d;
  logic next_rvalid;
  logic [31:0] next_rdata;

  always_comb begin
    next_rvalid = rd_d && !rst_i;
    next_rdata = rd_hit_d ? mem_rdata : '0;
    if (rst_i) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    rd_d <= req_i.rd && !rst_i;
    rd_hit_d <= req_i.rd && hit && !rst_i;
    rvalid_o <= next_rvalid;
    rdata_o <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Token accounting

  token_t used [NUM_GROUPS];
  token_t next_used [NUM_GROUPS];
  logic [NUM_ENGINES-1:0] next_grant;

  function automatic logic [GRP_W-1:0] grp_of(input logic [NUM_ENGINES*GRP_W-1:0] map,
                                               input int unsigned e);
    grp_of = map[e*GRP_W +: GRP_W];
  endfunction : grp_of

  always_comb begin
    int unsigned gi;
    gi = 0;
    next_used = used;
    next_grant = '0;
    for (int e = 0; e < NUM_ENGINES; e++) begin
      gi = 32'(grp_of(engine_group_i, e));
      // Unmapped group indices carry no budget
      if (give_back_i[e] && take_grant_o[e] == 1'b0 && gi < NUM_GROUPS
          && next_used[gi] != '0) begin
        next_used[gi] = token_t'(next_used[gi] - 1'b1);
      end
    end
    for (int e = 0; e < NUM_ENGINES; e++) begin
      gi = 32'(grp_of(engine_group_i, e));
      if (take_req_i[e] && gi < NUM_GROUPS) begin
        if (!caps_i.bw_tokens_supported) begin
          next_grant[e] = 1'b1;
        end else if (next_used[gi] < allowed[gi]) begin
          next_grant[e] = 1'b1;
          next_used[gi] = token_t'(next_used[gi] + 1'b1);
        end
      end
    end
    if (rst_i) begin
      next_grant = '0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        next_used[g] = '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    used <= next_used;
    take_grant_o <= next_grant;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      in_use_o[g*TOKEN_W +: TOKEN_W] <= next_used[g];
    end
  end

endmodule : group_bandwidth_token_limiter

// ==== token_limiter_sva.sv ====
module token_limiter_sva
  import token_limiter_pkg::*;
#(
  parameter int unsigned NUM_GROUPS = 4,
  parameter int unsigned NUM_ENGINES = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire reg_req_s req_i,
  input wire caps_s caps_i,
  input wire logic [NUM_ENGINES-1:0] take_req_i,
  input wire logic [NUM_ENGINES-1:0] give_back_i,
  input wire logic [NUM_ENGINES-1:0] take_grant_o,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [NUM_GROUPS*TOKEN_W-1:0] in_use_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Address that can never hold a token word
  logic stray_addr;
  assign stray_addr = (req_i.addr % GROUP_STRIDE) != TOKEN_CFG_OFFSET;

  sequence rd_s;
    req_i.rd ##2 rvalid_o;
  endsequence

  AST_RD_ANSWER: assert property (req_i.rd |-> rd_s)
    else $error("read not answered");
  AST_RV_CAUSE: assert property (rvalid_o |-> $past(req_i.rd, 2))
    else $error("answer without read");
  AST_UNMAPPED: assert property (req_i.rd && stray_addr |-> ##2 rdata_o == '0)
    else $error("unmapped read not zero");
  AST_RSVD_ZERO: assert property (rvalid_o |-> (rdata_o & 32'hf00f_00ff) == '0)
    else $error("reserved bits set");
  AST_IDLE_ZERO: assert property (!rvalid_o |-> rdata_o == '0)
    else $error("idle read data");
  AST_GRANT_REQ: assert property ((take_grant_o & ~$past(take_req_i)) == '0)
    else $error("grant without request");
  AST_IN_USE_HOLD: assert property (take_grant_o == '0 && $past(give_back_i) == '0
    |-> $stable(in_use_o))
    else $error("in use moved");
  AST_NO_LIMIT: assert property (!caps_i.bw_tokens_supported
    |=> take_grant_o == $past(take_req_i))
    else $error("limited without support");
endmodule : token_limiter_sva
bind group_bandwidth_token_limiter token_limiter_sva #(.NUM_GROUPS(NUM_GROUPS),
  .NUM_ENGINES(NUM_ENGINES)) sva_inst (.mclk_i, .rst_i, .req_i, .caps_i, .take_req_i,
  .give_back_i, .take_grant_o, .rdata_o, .rvalid_o, .in_use_o);

// ==== group_bandwidth_token_limiter_test.sv ====
module group_bandwidth_token_limiter_test import token_limiter_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_i = 1, device_enabled_i = 0, rvalid_o;
  reg_req_s req_i = '0;
  localparam int WATCHDOG_CYCLES = 1000;
  caps_s caps_i = '{1'b1, 1'b1, 8'h40};
  logic [7:0] engine_group_i = 8'h55;
  logic [3:0] take_req_i = '0, give_back_i = '0, take_grant_o;
  logic [31:0] rdata_o, in_use_o;
  int err_total = 0, checked = 0, n;
  // Address, write data, expected read-back
  logic [79:0] rows [5] = '{{16'h0428, 32'hf20f_08ff, 32'h0200_0800},
    {16'h0468, 32'h0100_0400, 32'h0100_0400}, {16'h04a8, 32'h008f_00f0, 32'h0080_0000},
    {16'h04e8, 32'h00c0_0200, 32'h00c0_0200}, {16'h0424, 32'h1234_5678, 32'h0000_0000}};
  group_bandwidth_token_limiter group_bandwidth_token_limiter_inst (.mclk_i, .rst_i, .req_i,
    .caps_i, .device_enabled_i, .engine_group_i, .take_req_i, .give_back_i, .take_grant_o,
    .rdata_o, .rvalid_o, .in_use_o);
  initial forever #10 mclk_i = ~mclk_i;
  ////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Request stands at one rising edge; an idle edge follows
  task automatic wr(logic [15:0] a, logic [31:0] d);
    req_i = '{1'b1, 1'b0, a, d};
    @(negedge mclk_i) req_i = '0;
    @(negedge mclk_i);
  endtask : wr
  task automatic rd(logic [15:0] a, logic [31:0] e);
    req_i = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge mclk_i) req_i = '0;
    @(negedge mclk_i);
    chk("rvalid", 32'h0000_0001, {31'h0, rvalid_o});
    chk("rdata", e, rdata_o);
  endtask : rd
  task automatic grab(logic [3:0] r, int cyc, logic [31:0] e);
    take_req_i = r;
    n = 0;
    repeat (cyc) @(negedge mclk_i) n += $countones(take_grant_o);
    take_req_i = '0;
    @(negedge mclk_i) n += $countones(take_grant_o);
    chk("grants", e, 32'(n));
  endtask : grab
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 0;
    repeat (5) @(negedge mclk_i);
    rd(16'h0428, 32'h0400_0000);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][79:64], rows[i][63:32]);
      rd(rows[i][79:64], rows[i][31:0]);
    end
    device_enabled_i = 1;
    wr(16'h0468, 32'h0140_0000);
    rd(16'h0468, 32'h0100_0400);
    device_enabled_i = 0;
    caps_i.config_supported = 0;
    wr(16'h0468, 32'h0140_0000);
    rd(16'h0468, 32'h0100_0400);
    caps_i.config_supported = 1;
    grab(4'h1, 18, 32'h0000_0010);
    chk("in_use", 32'h0000_0010, {24'h0, in_use_o[15:8]});
    give_back_i = 4'h1;
    @(negedge mclk_i) give_back_i = '0;
    @(negedge mclk_i);
    chk("in_use", 32'h0000_000f, {24'h0, in_use_o[15:8]});
    grab(4'h6, 4, 32'h0000_0001);
    caps_i.bw_tokens_supported = 0;
    grab(4'h8, 4, 32'h0000_0004);
    chk("in_use", 32'h0000_0010, {24'h0, in_use_o[15:8]});
    wr(16'h0428, 32'h0000_0000);
    rd(16'h0428, 32'h0200_0800);
    caps_i.bw_tokens_supported = 1;
    // Engine 3 moves to group 2, which has its own budget
    engine_group_i = 8'h95;
    grab(4'h8, 10, 32'h0000_0008);
    chk("in_use", 32'h0000_0008, {24'h0, in_use_o[23:16]});
    rst_i = 1;
    repeat (10) @(negedge mclk_i);
    chk("in_use_rst", 32'h0000_0000, in_use_o);
    chk("grant_rst", 32'h0000_0000, {28'h0, take_grant_o});
    chk("rvalid_rst", 32'h0000_0000, {31'h0, rvalid_o});
    rst_i = 0;
    repeat (5) @(negedge mclk_i);
    rd(16'h0468, 32'h0400_0000);
    grab(4'h1, 66, 32'h0000_0040);
    wrap_up();
  end
  initial begin
    repeat (WATCHDOG_CYCLES) @(negedge mclk_i);
    err_total++;
    wrap_up();
  end
endmodule : group_bandwidth_token_limiter_test
